/* stg_pkg.sv */
// Package with register map, field layout and timing constants of the gate timing registers.
package stg_pkg;
    localparam logic [7:0]  STG_ADDR_SAFE_CFG  = 8'h1b;
    localparam logic [7:0]  STG_ADDR_CAPTURE   = 8'h1c;
    localparam logic [15:0] STG_SAFE_CFG_RESET = 16'h2000;
    localparam logic [15:0] STG_CAPTURE_RESET  = 16'hff01;
    localparam int          STG_DELAY_MSB      = 15;
    localparam int          STG_DELAY_LSB      = 8;
    localparam int          STG_PLATEAU_MSB    = 7;
    localparam int          STG_PLATEAU_LSB    = 4;
    localparam int          STG_ARMED_BIT      = 7;
    localparam int          STG_REJECT_BIT     = 1;
    localparam int          STG_PARITY_BIT     = 0;
    localparam logic [7:0]  STG_DELAY_OFF      = 8'h00;
    localparam logic [7:0]  STG_COUNT_MAX      = 8'hff;

    // Fill in the odd parity bit of a readout word.
    function automatic logic [15:0] stg_odd_parity(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        r[STG_PARITY_BIT] = 1'b0;
        r[STG_PARITY_BIT] = ~(^r);
        return r;
    endfunction
endpackage

/* stg_delay_timer.sv */
// Down counter that times the two-level turn-off plateau phase.
`timescale 1ns/10ps
`default_nettype none
module stg_delay_timer
    import stg_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Control.
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] delay,
    // Status.
    output logic                  busy,
    output logic                  done
);
    // A counter without bits could never hold a delay, so refuse it early.
    if (WIDTH < 1)
    begin : g_width_check
        $error("stg_delay_timer: WIDTH must be at least 1");
    end

    typedef struct packed
    {
        logic [WIDTH-1:0] cnt;
        logic             busy;
        logic             done;
    } stg_tmr_t;

    stg_tmr_t s_q;
    stg_tmr_t s_d;

    // A zero delay never starts, so the plateau phase is skipped entirely.
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (start && (delay != '0))
        begin
            s_d.busy = 1'b1;
            s_d.cnt  = delay;
        end
        else if (s_q.busy)
        begin
            s_d.cnt = s_q.cnt - 1'b1;
            if (s_q.cnt == WIDTH'(1))
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule // stg_delay_timer
`default_nettype wire

/* stg_regs.sv */
// Safe two-level turn-off configuration and turn-off timing capture registers.
`timescale 1ns/10ps
`default_nettype none
module stg_regs
    import stg_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Register access from the link decoder, same clock domain.
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        last_frame_rejected,
    // Regular turn-off delay from the neighbouring register.
    input  wire logic [7:0]  regular_off_delay,
    // Turn-off events, same clock domain.
    input  wire logic        safe_off_start,
    input  wire logic        regular_off_start,
    input  wire logic        capture_request,
    input  wire logic        gate_edge,
    // Outputs.
    output logic [15:0]      rdata,
    output logic             rdata_valid,
    output logic             plateau_active,
    output logic [3:0]       plateau_level
);
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_MEASURE} stg_cap_t;

    // Field widths, derived from the field positions.
    localparam int DELAY_W   = STG_DELAY_MSB - STG_DELAY_LSB + 1;
    localparam int PLATEAU_W = STG_PLATEAU_MSB - STG_PLATEAU_LSB + 1;

    ////////////////////////////////////////////////////////////////////////
    // The ports carry one byte of delay and one nibble of plateau level, so
    // a field layout that disagrees with them is refused at elaboration.
    if (DELAY_W != 8)
    begin : g_delay_width_check
        $error("stg_regs: delay field must be one byte wide");
    end
    if (PLATEAU_W != 4)
    begin : g_plateau_width_check
        $error("stg_regs: plateau field must be four bits wide");
    end
    // Flag and parity must stay clear of the fields, or assembling the
    // readout word would overwrite part of a field.
    if (STG_REJECT_BIT <= STG_PARITY_BIT ||
        STG_REJECT_BIT >= STG_PLATEAU_LSB ||
        STG_ARMED_BIT >= STG_DELAY_LSB)
    begin : g_bit_layout_check
        $error("stg_regs: flag bits overlap a register field");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the write path and the read path.
    function automatic logic stg_addr_hit(
        input logic [7:0] a,
        input logic [7:0] target
    );
        return a == target;
    endfunction

    // Readout of the safe configuration: delay byte and plateau nibble.
    function automatic logic [15:0] stg_safe_word(
        input logic [7:0] dly,
        input logic [3:0] lvl
    );
        logic [15:0] w;
        w                                  = 16'h0000;
        w[STG_DELAY_MSB:STG_DELAY_LSB]     = dly;
        w[STG_PLATEAU_MSB:STG_PLATEAU_LSB] = lvl;
        return w;
    endfunction

    // Readout of the capture register: count byte and armed flag.
    function automatic logic [15:0] stg_capture_word(
        input logic [7:0] cnt,
        input logic       armed
    );
        logic [15:0] w;
        w                              = 16'h0000;
        w[STG_DELAY_MSB:STG_DELAY_LSB] = cnt;
        w[STG_ARMED_BIT]               = armed;
        return w;
    endfunction

    typedef struct packed
    {
        logic [7:0]  safe_off_delay;
        logic [3:0]  safe_off_plateau_level;
        logic [7:0]  turnoff_timing_count;
        logic        turnoff_capture_armed;
        stg_cap_t    cap;
        logic [3:0]  level;
        logic        plateau;
        logic [15:0] rdata;
        logic        rvalid;
    } stg_regs_t;

    stg_regs_t s_q;
    stg_regs_t s_d;
    logic      tmr_busy;
    logic      tmr_start;
    logic [7:0] tmr_delay;

    ////////////////////////////////////////////////////////////////////////
    // Plateau timer, shared by safe and regular turn-off.
    assign tmr_start = safe_off_start | regular_off_start;
    assign tmr_delay = safe_off_start ? s_q.safe_off_delay
                                      : regular_off_delay;

    stg_delay_timer #(.WIDTH(DELAY_W)) u_timer
    (
        .clk   (clk),
        .rst   (rst),
        .start (tmr_start),
        .delay (tmr_delay),
        .busy  (tmr_busy),
        .done  ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state: configuration writes, capture machine and readout.
    always_comb
    begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        // A write and a safe start in one cycle: the start still uses the
        // old delay, since the timer is loaded from the stored register.
        if (wr_en && stg_addr_hit(addr, STG_ADDR_SAFE_CFG))
        begin
            s_d.safe_off_delay =
                wdata[STG_DELAY_MSB:STG_DELAY_LSB];
            s_d.safe_off_plateau_level =
                wdata[STG_PLATEAU_MSB:STG_PLATEAU_LSB];
        end
        // The plateau level follows the safe field only on safe starts.
        if (safe_off_start && s_q.safe_off_delay != STG_DELAY_OFF)
        begin
            s_d.level = s_q.safe_off_plateau_level;
        end
        s_d.plateau = tmr_busy;
        // Capture machine; a second request while armed disarms it.
        case (s_q.cap)
            ST_IDLE:
            begin
                if (capture_request)
                begin
                    s_d.cap                   = ST_ARMED;
                    s_d.turnoff_capture_armed = 1'b1;
                end
            end
            ST_ARMED:
            begin
                if (capture_request)
                begin
                    s_d.cap                   = ST_IDLE;
                    s_d.turnoff_capture_armed = 1'b0;
                end
                else if (tmr_start)
                begin
                    s_d.cap                  = ST_MEASURE;
                    s_d.turnoff_timing_count = '0;
                end
            end
            ST_MEASURE:
            begin
                if (capture_request)
                begin
                    s_d.cap                   = ST_IDLE;
                    s_d.turnoff_capture_armed = 1'b0;
                end
                else if (gate_edge)
                begin
                    s_d.cap                   = ST_IDLE;
                    s_d.turnoff_capture_armed = 1'b0;
                end
                // The count saturates, so a lost gate edge cannot wrap
                // back to a short and plausible looking reading.
                else if (s_q.turnoff_timing_count != STG_COUNT_MAX)
                begin
                    s_d.turnoff_timing_count =
                        s_q.turnoff_timing_count + 8'h01;
                end
            end
            default:
            begin
                s_d.cap = ST_IDLE;
            end
        endcase
        // Readout word with rejection flag and parity filled in.
        if (rd_en)
        begin
            s_d.rvalid = 1'b1;
            if (stg_addr_hit(addr, STG_ADDR_SAFE_CFG))
                s_d.rdata = stg_safe_word(s_q.safe_off_delay,
                                          s_q.safe_off_plateau_level);
            else if (stg_addr_hit(addr, STG_ADDR_CAPTURE))
                s_d.rdata = stg_capture_word(
                    s_q.turnoff_timing_count,
                    s_q.turnoff_capture_armed);
            else
                s_d.rdata = 16'h0000;
            s_d.rdata[STG_REJECT_BIT] = last_frame_rejected;
            s_d.rdata = stg_odd_parity(s_d.rdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register with documented reset values.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q                        <= '0;
            s_q.safe_off_delay         <=
                STG_SAFE_CFG_RESET[STG_DELAY_MSB:STG_DELAY_LSB];
            s_q.safe_off_plateau_level <=
                STG_SAFE_CFG_RESET[STG_PLATEAU_MSB:STG_PLATEAU_LSB];
            s_q.turnoff_timing_count   <=
                STG_CAPTURE_RESET[STG_DELAY_MSB:STG_DELAY_LSB];
            s_q.turnoff_capture_armed  <= STG_CAPTURE_RESET[STG_ARMED_BIT];
            s_q.cap                    <= ST_IDLE;
        end
        else
            s_q <= s_d;
    end

    assign rdata          = s_q.rdata;
    assign rdata_valid    = s_q.rvalid;
    assign plateau_active = s_q.plateau;
    assign plateau_level  = s_q.level;
endmodule // stg_regs
`default_nettype wire

/* stg_regs_asserts.sv */
// Checker on the ports of the gate timing register bank.
`timescale 1ns/10ps
`default_nettype none
module stg_regs_asserts
(
    // Clock, reset, access and turn-off starts.
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        last_frame_rejected,
    input wire logic        safe_off_start,
    input wire logic        regular_off_start,
    // Readout and plateau.
    input wire logic [15:0] rdata,
    input wire logic        rdata_valid,
    input wire logic        plateau_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A write of the safe config, then one cycle without a write, then its read.
    sequence s_wr; wr_en && addr == 8'h1b; endsequence
    sequence s_gap; !wr_en; endsequence
    sequence s_rd; rd_en && addr == 8'h1b; endsequence
    property p_wrrd;
        s_wr ##1 s_gap ##1 s_rd |=> rdata[15:4] == $past(wdata[15:4], 3);
    endproperty
    property p_valid; rd_en |=> rdata_valid; endproperty
    property p_hold; !rd_en |=> !rdata_valid && $stable(rdata); endproperty
    property p_par; rdata_valid |-> ^rdata; endproperty
    property p_rej; rd_en |=> rdata[1] == $past(last_frame_rejected);
    endproperty
    property p_cap; rd_en && addr == 8'h1c |=> rdata[6:2] == 5'h00;
    endproperty
    property p_unm;
        rd_en && addr != 8'h1b && addr != 8'h1c |=> rdata[15:2] == 14'h0000;
    endproperty
    // The plateau can only start two cycles after a turn-off start.
    property p_plat;
        $rose(plateau_active) |-> $past(safe_off_start | regular_off_start, 2);
    endproperty
    a_wrrd: assert property (p_wrrd) else $error("readback differs");
    a_valid: assert property (p_valid) else $error("no valid");
    a_hold: assert property (p_hold) else $error("readout moved");
    a_par: assert property (p_par) else $error("even parity");
    a_rej: assert property (p_rej) else $error("reject bit");
    a_cap: assert property (p_cap) else $error("reserved set");
    a_unm: assert property (p_unm) else $error("unmapped data");
    a_plat: assert property (p_plat) else $error("plateau start");
endmodule // stg_regs_asserts
bind stg_regs stg_regs_asserts u_chk (.*);
`default_nettype wire

/* stg_host.sv */
// Host model issuing register accesses to the timing registers.
`timescale 1ns/10ps
`default_nettype none
module stg_host
(
    // Clock and readout.
    input  wire logic        clk,
    input  wire logic [15:0] rdata,
    // Register access.
    output logic             wr_en,
    output logic             rd_en,
    output logic [7:0]       addr,
    output logic [15:0]      wdata,
    output logic             last_frame_rejected
);
    initial {wr_en, rd_en, addr, wdata, last_frame_rejected} = '0;
    // Released lines show the inverse so a stale value is never trusted.
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr_en <= 1'b0;
        addr <= ~a;
        wdata <= ~v;
    endtask
    // Readout is registered, so it is taken just after the accepting edge.
    task automatic rd(input logic [7:0] a, input logic j,
                      output logic [15:0] v);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        last_frame_rejected <= j;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        #1 v = rdata;
    endtask
endmodule // stg_host
`default_nettype wire

/* tb.sv */
// Testbench of the safe turn-off and capture registers.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t line %0d", $time, `__LINE__); end end
module tb
    import stg_pkg::*;
;
    localparam logic [7:0] CFG = STG_ADDR_SAFE_CFG;
    localparam logic [7:0] CAP = STG_ADDR_CAPTURE;
    logic        clk = 0, rst = 1, wr_en, rd_en, lfr, pa, rdv;
    logic [7:0]  addr, rod = 8'h03;
    logic [15:0] wdata, rdata, d;
    logic [3:0]  ev = '0, pl;
    int          bad_count = 0, cmp_count = 0, n;
    stg_host host (.clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .last_frame_rejected(lfr));
    stg_regs uut (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wdata(wdata), .last_frame_rejected(lfr),
        .regular_off_delay(rod), .safe_off_start(ev[0]),
        .regular_off_start(ev[1]), .capture_request(ev[2]),
        .gate_edge(ev[3]), .rdata(rdata), .rdata_valid(rdv),
        .plateau_active(pa), .plateau_level(pl));
    initial forever #25 clk = ~clk;
    // Own odd parity so no design function decides the expectation.
    function automatic logic [15:0] op(input logic [15:0] w);
        op = {w[15:1], ~^w[15:1]};
    endfunction
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= '0;
    endtask
    // Counts plateau cycles in a window far longer than any delay used.
    task automatic meas(input logic [3:0] m);
        pulse(m);
        n = 0;
        repeat (40) begin @(posedge clk); #1 n += int'(pa === 1'b1); end
    endtask
    task automatic finish_test;
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin #300us; bad_count++; finish_test; end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        host.rd(CFG, 1'b0, d); `CHK(d, op(16'h2000))
        `CHK(rdv, 1'b1)
        host.rd(CAP, 1'b0, d); `CHK(d, 16'hff01)
        host.wr(CFG, 16'h0a50);
        host.rd(CFG, 1'b1, d); `CHK(d, op(16'h0a52))
        host.wr(CAP, 16'h1234);
        host.rd(CAP, 1'b0, d); `CHK(d, 16'hff01)
        host.rd(8'h1d, 1'b1, d); `CHK(d, 16'h0002)
        meas(4'h1); `CHK(n, 10)
        `CHK(pl, 4'h5)
        meas(4'h2); `CHK(n, 3)
        host.wr(CFG, 16'h0030);
        meas(4'h1); `CHK(n, 0)
        pulse(4'h4);
        host.rd(CAP, 1'b0, d); `CHK(d, op(16'hff80))
        pulse(4'h1);
        repeat (4) @(posedge clk);
        pulse(4'h8);
        host.rd(CAP, 1'b0, d); `CHK(d[7], 1'b0)
        `CHK(d[15:8], 8'h05)
        pulse(4'h4);
        pulse(4'h4);
        host.rd(CAP, 1'b0, d); `CHK(d[7], 1'b0)
        // A reset in mid-run with capture armed restores every reset value.
        pulse(4'h4);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        `CHK(pl, 4'h0)
        host.rd(CAP, 1'b0, d); `CHK(d, op(16'hff00))
        host.rd(CFG, 1'b0, d); `CHK(d, op(16'h2000))
        finish_test;
    end
endmodule // tb
`default_nettype wire
